//--- hdl/twsda_regs.vh
// Purpose: register map, fields, reset values and codes of the two-wire core
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   status codes are full bytes; the 5-bit field is code[7:3]
`ifndef TWSDA_REGS_VH
`define TWSDA_REGS_VH
`define TWSDA_OFS_STATUS    8'hb9
`define TWSDA_OFS_ADDR      8'hba
`define TWSDA_OFS_DATA      8'hbb
`define TWSDA_OFS_CTRL      8'hbc
`define TWSDA_OFS_MASK      8'hbd
`define TWSDA_OFS_RATE      8'hb8
`define TWSDA_RST_DATA      8'hff
`define TWSDA_RST_ZERO      8'h00
`define TWSDA_CTRL_DONE     7
`define TWSDA_CTRL_ACKEN    6
`define TWSDA_CTRL_STOP     4
`define TWSDA_CTRL_WCOL     3
`define TWSDA_CTRL_EN       2
`define TWSDA_ST_MR_NACK    8'h58
`define TWSDA_ST_SR_SLA     8'h60
`define TWSDA_ST_SR_SLA_AL  8'h68
`define TWSDA_ST_SR_GC      8'h70
`define TWSDA_ST_SR_GC_AL   8'h78
`define TWSDA_ST_SR_D_ACK   8'h80
`define TWSDA_ST_SR_D_NACK  8'h88
`define TWSDA_ST_GC_D_ACK   8'h90
`define TWSDA_ST_GC_D_NACK  8'h98
`define TWSDA_ST_SR_STOP    8'ha0
`define TWSDA_ST_ST_SLA     8'ha8
`define TWSDA_ST_ST_SLA_AL  8'hb0
`define TWSDA_ST_ST_D_ACK   8'hb8
`define TWSDA_ST_ST_D_NACK  8'hc0
`define TWSDA_ST_ST_LAST    8'hc8
`define TWSDA_ST_IDLE       8'hf8
`define TWSDA_ST_MR_ACK     8'h50
`endif

//--- hdl/twsda_sync.v
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: pin asynchronous to sys_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
module twsda_sync (
  input  wire sys_clk,
  input  wire nrst,
  input  wire pin_in,
  output reg  level_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end
endmodule // twsda_sync

//--- hdl/twsda_core.v
// Purpose: two-wire serial core, slave modes only; master-receiver codes unreachable, master_rx_reg is never set
// Assumes: external pull-ups; pins sampled on sys_clk; open-drain outputs
// Notes:   no master start/address phase or bus claim; master_rx_reg and lost_arb_reg are only ever cleared
// Contract
// - Master receiver data NACK reports 0x58
// - Slave write address or general call codes
// - Slave received data codes 0x80-0x98
// - Stop or restart while addressed reports 0xA0
// - Slave read address reports 0xA8/0xB0
// - Slave transmit codes 0xB8/0xC0/0xC8
// - Idle with done clear reads 0xF8
// - Reserved status/mask bits read zero
// - Two-bit prescaler readable, selects 1/4/16/64
// - Data register: byte to send or received
// - Data writable only while done set
// - No data initialise before first done
// - Shift in while shifting out
// - Keep byte on lost arbitration
// - Acknowledge handled automatically, not visible
// - Compare address with bits 7:1, flag match
// - Bit 0 enables general call match
// - Mask bits exclude address bits
// - Status code in bits 7:3
// - Hold SCL low while done set
// - Write collision set/clear on data write
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "twsda_regs.vh"
module twsda_core (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe_n,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  output reg        transfer_done_flag,
  output reg        prescale_tick
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_ADDR = 5'b00010;
  localparam [4:0] S_RX   = 5'b00100;
  localparam [4:0] S_TX   = 5'b01000;
  localparam [4:0] S_ACK  = 5'b10000;

  wire scl_s;
  wire sda_s;
  twsda_sync u_scl (.sys_clk(sys_clk), .nrst(nrst), .pin_in(scl_in), .level_reg(scl_s));
  twsda_sync u_sda (.sys_clk(sys_clk), .nrst(nrst), .pin_in(sda_in), .level_reg(sda_s));

  reg  [7:0] slave_address_match_reg;
  reg  [7:0] serial_byte_buffer_reg;
  reg  [7:0] slave_address_ignore_bits_reg;
  reg  [7:0] bus_state_code_reg;
  reg  [1:0] bit_rate_prescale_select_reg;
  reg  [7:0] bit_rate_reg;
  reg        acknowledge_enable_reg;
  reg        enable_reg;
  reg        write_collision_flag_reg;
  reg        first_done_seen_reg;
  reg  [4:0] state_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg        addressed_reg;
  reg        gc_reg;
  reg        reading_reg;
  reg        last_byte_reg;
  reg        ack_drive_reg;
  reg        lost_arb_reg;
  reg        master_rx_reg;
  reg        byte_full_reg;
  reg  [13:0] pre_cnt_reg;
  reg        set_done;
  reg  [7:0] set_code;

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire [6:0] ignore = slave_address_ignore_bits_reg[7:1];
  wire own_hit = ((shift_reg[7:1] ^ slave_address_match_reg[7:1]) & ~ignore) == 7'h00;
  wire gc_hit  = (shift_reg[7:1] == 7'h00) && slave_address_match_reg[0];
  wire done_clear = reg_wr && reg_addr == `TWSDA_OFS_CTRL && reg_wdata[`TWSDA_CTRL_DONE];

  // Prescale divider: tick period 1/4/16/64 times (rate+1) sys clocks
  reg [13:0] pre_lim;
  always @* begin
    case (bit_rate_prescale_select_reg)
      2'd0:    pre_lim = {6'h00, bit_rate_reg};
      2'd1:    pre_lim = {4'h0, bit_rate_reg, 2'b11};
      2'd2:    pre_lim = {2'h0, bit_rate_reg, 4'hf};
      default: pre_lim = {bit_rate_reg, 6'h3f};
    endcase
  end
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pre_cnt_reg   <= 14'h0000;
      prescale_tick <= 1'b0;
    end else if (pre_cnt_reg >= pre_lim) begin
      pre_cnt_reg   <= 14'h0000;
      prescale_tick <= 1'b1;
    end else begin
      pre_cnt_reg   <= pre_cnt_reg + 14'h0001;
      prescale_tick <= 1'b0;
    end
  end

  // Bus engine; event codes registered in set_code, then latched with done one cycle later
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg     <= S_IDLE;
      bit_cnt_reg   <= 3'd0;
      shift_reg     <= `TWSDA_RST_DATA;
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
      addressed_reg <= 1'b0;
      gc_reg        <= 1'b0;
      reading_reg   <= 1'b0;
      last_byte_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      byte_full_reg <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_n      <= 1'b1;
      set_done      <= 1'b0;
      set_code      <= `TWSDA_ST_IDLE;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      sda_out   <= 1'b0;
      set_done  <= 1'b0;
      if (!enable_reg) begin
        state_reg     <= S_IDLE;
        addressed_reg <= 1'b0;
        sda_oe_n      <= 1'b1;
      end else if (start_c || stop_c) begin
        if (addressed_reg) begin
          set_done <= 1'b1;
          set_code <= `TWSDA_ST_SR_STOP;
        end
        addressed_reg <= 1'b0;
        sda_oe_n      <= 1'b1;
        bit_cnt_reg   <= 3'd0;
        byte_full_reg <= 1'b0;
        state_reg     <= start_c ? S_ADDR : S_IDLE;
      end else begin
        case (state_reg)
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              shift_reg     <= {shift_reg[6:0], sda_s};
              bit_cnt_reg   <= bit_cnt_reg + 3'd1;
              byte_full_reg <= (bit_cnt_reg == 3'd7);
            end
            // Full flag keeps the fall that ends a start from counting as a byte
            if (scl_fall && byte_full_reg && !transfer_done_flag) begin
              byte_full_reg <= 1'b0;
              if (state_reg == S_ADDR) begin
                if (acknowledge_enable_reg && (own_hit || gc_hit)) begin
                  addressed_reg <= 1'b1;
                  gc_reg        <= gc_hit && !own_hit;
                  reading_reg   <= shift_reg[0] && !gc_hit;
                  ack_drive_reg <= 1'b1;
                  sda_oe_n      <= 1'b0;
                  set_done      <= 1'b1;
                  if (shift_reg[0] && !gc_hit) begin
                    set_code <= lost_arb_reg ? `TWSDA_ST_ST_SLA_AL : `TWSDA_ST_ST_SLA;
                  end else if (gc_hit && !own_hit) begin
                    set_code <= lost_arb_reg ? `TWSDA_ST_SR_GC_AL : `TWSDA_ST_SR_GC;
                  end else begin
                    set_code <= lost_arb_reg ? `TWSDA_ST_SR_SLA_AL : `TWSDA_ST_SR_SLA;
                  end
                  state_reg <= S_ACK;
                end else begin
                  state_reg <= S_IDLE;
                end
              end else begin
                ack_drive_reg <= acknowledge_enable_reg;
                sda_oe_n      <= ~acknowledge_enable_reg;
                set_done      <= 1'b1;
                if (master_rx_reg) begin
                  set_code <= acknowledge_enable_reg ? `TWSDA_ST_MR_ACK : `TWSDA_ST_MR_NACK;
                end else if (gc_reg) begin
                  set_code <= acknowledge_enable_reg ? `TWSDA_ST_GC_D_ACK
                                                     : `TWSDA_ST_GC_D_NACK;
                end else begin
                  set_code <= acknowledge_enable_reg ? `TWSDA_ST_SR_D_ACK
                                                     : `TWSDA_ST_SR_D_NACK;
                end
                if (!acknowledge_enable_reg) begin
                  addressed_reg <= 1'b0;
                end
                state_reg <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              ack_drive_reg <= 1'b0;
              sda_oe_n      <= 1'b1;
              bit_cnt_reg   <= 3'd0;
              if (!addressed_reg) begin
                state_reg <= S_IDLE;
              end else if (reading_reg) begin
                last_byte_reg <= ~acknowledge_enable_reg;
                sda_oe_n      <= serial_byte_buffer_reg[7];
                state_reg     <= S_TX;
              end else begin
                state_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              if (ack_drive_reg) begin
                ack_drive_reg <= 1'b0;
                set_done      <= 1'b1;
                bit_cnt_reg   <= 3'd0;
                if (sda_s) begin
                  set_code      <= `TWSDA_ST_ST_D_NACK;
                  addressed_reg <= 1'b0;
                  state_reg     <= S_IDLE;
                end else begin
                  set_code <= last_byte_reg ? `TWSDA_ST_ST_LAST : `TWSDA_ST_ST_D_ACK;
                end
              end else begin
                bit_cnt_reg   <= bit_cnt_reg + 3'd1;
                ack_drive_reg <= (bit_cnt_reg == 3'd7);
              end
            end else if (!scl_s) begin
              // Driven all through the low phase, so a byte loaded during the stretch goes out
              sda_oe_n <= ack_drive_reg | serial_byte_buffer_reg[3'd7 - bit_cnt_reg];
            end
          end
          default: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Register file, done flag and status
  always @(posedge sys_clk) begin
    if (!nrst) begin
      slave_address_match_reg       <= `TWSDA_RST_ZERO;
      serial_byte_buffer_reg        <= `TWSDA_RST_DATA;
      slave_address_ignore_bits_reg <= `TWSDA_RST_ZERO;
      bus_state_code_reg            <= `TWSDA_ST_IDLE;
      bit_rate_prescale_select_reg  <= 2'b00;
      bit_rate_reg                  <= `TWSDA_RST_ZERO;
      acknowledge_enable_reg        <= 1'b0;
      enable_reg                    <= 1'b0;
      write_collision_flag_reg      <= 1'b0;
      first_done_seen_reg           <= 1'b0;
      transfer_done_flag            <= 1'b0;
      lost_arb_reg                  <= 1'b0;
      master_rx_reg                 <= 1'b0;
      reg_rdata                     <= 8'h00;
      scl_out                       <= 1'b0;
      scl_oe_n                      <= 1'b1;
    end else begin
      scl_oe_n <= ~transfer_done_flag;
      if (set_done) begin
        transfer_done_flag  <= 1'b1;
        bus_state_code_reg  <= set_code;
        first_done_seen_reg <= 1'b1;
        if (state_reg != S_TX) begin
          serial_byte_buffer_reg <= shift_reg;
        end
      end else if (done_clear) begin
        transfer_done_flag <= 1'b0;
        bus_state_code_reg <= `TWSDA_ST_IDLE;
      end
      if (reg_wr) begin
        if (reg_addr == `TWSDA_OFS_ADDR) begin
          slave_address_match_reg <= reg_wdata;
        end else if (reg_addr == `TWSDA_OFS_MASK) begin
          slave_address_ignore_bits_reg <= {reg_wdata[7:1], 1'b0};
        end else if (reg_addr == `TWSDA_OFS_STATUS) begin
          bit_rate_prescale_select_reg <= reg_wdata[1:0];
        end else if (reg_addr == `TWSDA_OFS_RATE) begin
          bit_rate_reg <= reg_wdata;
        end else if (reg_addr == `TWSDA_OFS_CTRL) begin
          acknowledge_enable_reg <= reg_wdata[`TWSDA_CTRL_ACKEN];
          enable_reg             <= reg_wdata[`TWSDA_CTRL_EN];
          if (reg_wdata[`TWSDA_CTRL_STOP]) begin
            lost_arb_reg  <= 1'b0;
            master_rx_reg <= 1'b0;
          end
        end else if (reg_addr == `TWSDA_OFS_DATA) begin
          if (transfer_done_flag && first_done_seen_reg && !set_done) begin
            serial_byte_buffer_reg   <= reg_wdata;
            write_collision_flag_reg <= 1'b0;
          end else begin
            write_collision_flag_reg <= 1'b1;
          end
        end
      end
      if (reg_rd) begin
        if (reg_addr == `TWSDA_OFS_STATUS) begin
          reg_rdata <= {bus_state_code_reg[7:3], 1'b0, bit_rate_prescale_select_reg};
        end else if (reg_addr == `TWSDA_OFS_ADDR) begin
          reg_rdata <= slave_address_match_reg;
        end else if (reg_addr == `TWSDA_OFS_DATA) begin
          reg_rdata <= serial_byte_buffer_reg;
        end else if (reg_addr == `TWSDA_OFS_MASK) begin
          reg_rdata <= slave_address_ignore_bits_reg;
        end else if (reg_addr == `TWSDA_OFS_RATE) begin
          reg_rdata <= bit_rate_reg;
        end else if (reg_addr == `TWSDA_OFS_CTRL) begin
          reg_rdata <= {transfer_done_flag, acknowledge_enable_reg, 1'b0, 1'b0,
                        write_collision_flag_reg, enable_reg, 2'b00};
        end else begin
          reg_rdata <= 8'h00;
        end
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
endmodule // twsda_core

//--- bench/twsda_core_monitor.sv
// Purpose: port-level checks of the two-wire core
// Assumes: read data answers one cycle after the strobe
// Notes:   bound to every core instance
`timescale 1ns/1ps
`include "twsda_regs.vh"
module twsda_core_monitor (
  input wire       sys_clk,
  input wire       nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe_n,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_n,
  input wire       transfer_done_flag,
  input wire       prescale_tick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire st_rd = reg_rd && reg_addr == `TWSDA_OFS_STATUS;
  property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data without read");
  property p_st_res; st_rd |=> !reg_rdata[2]; endproperty
  a_st_res: assert property (p_st_res) else $error("status bit 2 set");
  property p_mk_res; reg_rd && reg_addr == `TWSDA_OFS_MASK |=> !reg_rdata[0]; endproperty
  a_mk_res: assert property (p_mk_res) else $error("mask bit 0 set");
  property p_idle; st_rd && !transfer_done_flag |=> reg_rdata[7:3] == 5'h1f; endproperty
  a_idle: assert property (p_idle) else $error("idle code wrong");
  property p_busy; st_rd && transfer_done_flag |=> reg_rdata[7:3] != 5'h1f; endproperty
  a_busy: assert property (p_busy) else $error("idle code with done set");
  property p_hold; transfer_done_flag ##1 transfer_done_flag |-> !scl_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("clock released while done");
  property p_free; !transfer_done_flag ##1 !transfer_done_flag |-> scl_oe_n; endproperty
  a_free: assert property (p_free) else $error("clock held while not done");
  property p_od; scl_out == 1'b0 && sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  c_done: cover property ($rose(transfer_done_flag));
  c_ack: cover property ($fell(sda_oe_n));
  c_stat: cover property (st_rd && transfer_done_flag);
endmodule // twsda_core_monitor

bind twsda_core twsda_core_monitor u_mon (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .transfer_done_flag(transfer_done_flag),
  .prescale_tick(prescale_tick));

//--- bench/twsda_master_bfm.sv
// Purpose: bit-level bus master at the far side of the core
// Assumes: pull-ups on both lines; 48 ns bit period
// Notes:   waits out clock stretching; idles with both lines released
`timescale 1ns/1ps
module twsda_master_bfm (
  output reg  scl_drv,
  output reg  sda_drv,
  input  wire scl_line,
  input  wire sda_line
);
  localparam q_ns = 12;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Slave may stretch the low phase
  task clk_hi;
    scl_drv = 1'b1;
    wait (scl_line === 1'b1);
  endtask
  // 48 ns slot: 36 ns low, 12 ns high; long low covers the slave's pin latency
  task bit_out(input b);
    sda_drv = b;
    #(2*q_ns);
    clk_hi;
    #q_ns;
    scl_drv = 1'b0;
    #q_ns;
  endtask
  task bit_in(output s);
    sda_drv = 1'b1;
    #(2*q_ns);
    clk_hi;
    #(q_ns/2);
    s = sda_line;
    #(q_ns/2);
    scl_drv = 1'b0;
    #q_ns;
  endtask
  // Waits until the slave lets go of the clock before claiming the bus
  task start;
    clk_hi;
    #q_ns;
    sda_drv = 1'b0;
    #q_ns;
    scl_drv = 1'b0;
    #q_ns;
  endtask
  task stop;
    sda_drv = 1'b0;
    #(2*q_ns);
    clk_hi;
    #q_ns;
    sda_drv = 1'b1;
    #(2*q_ns);
  endtask
  task send(input [7:0] b, output nack);
    integer i;
    for (i = 7; i >= 0; i = i - 1) bit_out(b[i]);
    sda_drv = 1'b1;
    // Slave raises done on the eighth fall; give it time to stretch
    #(4*q_ns);
    bit_in(nack);
  endtask
  task recv(output [7:0] b, input give_ack);
    integer i;
    for (i = 7; i >= 0; i = i - 1) bit_in(b[i]);
    bit_out(~give_ack);
  endtask
endmodule // twsda_master_bfm

//--- bench/tb.sv
// Purpose: self-checking bench for the two-wire core
// Assumes: master model stands for the far side
// Notes:   register bus answers one cycle after the read strobe
`timescale 1ns/1ps
`include "twsda_regs.vh"
module tb;
  localparam [7:0] a_st = `TWSDA_OFS_STATUS, a_ad = `TWSDA_OFS_ADDR, a_dt = `TWSDA_OFS_DATA;
  localparam [7:0] a_ct = `TWSDA_OFS_CTRL, a_mk = `TWSDA_OFS_MASK, a_rt = `TWSDA_OFS_RATE;
  reg        sys_clk   = 1'b0;
  reg        nrst      = 1'b0;
  reg  [7:0] reg_addr  = 8'h00;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr    = 1'b0;
  reg        reg_rd    = 1'b0;
  wire [7:0] reg_rdata;
  wire       scl_o, scl_oe_n, sda_o, sda_oe_n, done, tick, m_scl, m_sda;
  wire       scl_line  = m_scl & (scl_oe_n | scl_o);
  wire       sda_line  = m_sda & (sda_oe_n | sda_o);
  integer    failures  = 0;
  integer    cmp_count = 0;
  integer    cyc       = 0;
  reg  [7:0] d;
  reg        nack;
  always #2.5 sys_clk = ~sys_clk;
  twsda_core dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_line),
    .scl_out(scl_o), .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_o),
    .sda_oe_n(sda_oe_n), .transfer_done_flag(done), .prescale_tick(tick));
  twsda_master_bfm m (.scl_drv(m_scl), .sda_drv(m_sda), .scl_line(scl_line), .sda_line(sda_line));
  task chk(input string w, input [7:0] e, input [7:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rc(input string w, input [7:0] a, input [7:0] k, input [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(w, e, reg_rdata & k);
  endtask
  task wait_done;
    integer i;
    @(negedge sys_clk);
    for (i = 0; i < 4000 && done !== 1'b1; i = i + 1) @(negedge sys_clk);
    chk("done", 8'h01, {7'h0, done});
  endtask
  task xfer(input [7:0] b, input [7:0] st, input [7:0] wd);
    fork
      m.send(b, nack);
      begin
        wait_done;
        rc("status", a_st, 8'hf8, st);
        if (st == 8'h80 || st == 8'h90) rc("rx byte", a_dt, 8'hff, b);
        wr(a_dt, wd);
        rc("collision", a_ct, 8'h08, 8'h00);
        wr(a_ct, 8'hc4);
      end
    join
    chk("ack", 8'h00, {7'h0, nack});
  endtask
  task xget(input ga, input [7:0] st, input [7:0] e, input [7:0] wd);
    fork
      m.recv(d, ga);
      begin
        wait_done;
        rc("status", a_st, 8'hf8, st);
        wr(a_dt, wd);
        wr(a_ct, 8'hc4);
      end
    join
    chk("tx byte", e, d);
  endtask
  task xstop;
    fork
      m.stop;
      begin
        wait_done;
        rc("status", a_st, 8'hf8, 8'ha0);
        wr(a_ct, 8'hc4);
      end
    join
  endtask
  task t_reset;
    rc("status", a_st, 8'hff, 8'hf8);
    rc("data", a_dt, 8'hff, 8'hff);
    rc("address", a_ad, 8'hff, 8'h00);
    rc("mask", a_mk, 8'hff, 8'h00);
    wr(a_dt, 8'h5a);
    rc("early data", a_dt, 8'hff, 8'hff);
    rc("collision", a_ct, 8'h08, 8'h08);
    $display("test reset done");
  endtask
  task to_tick(output integer n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n = n + 1;
    end while (tick !== 1'b1 && n < 300);
  endtask
  task t_rate;
    integer p, n;
    wr(a_rt, 8'h01);
    for (p = 0; p < 4; p = p + 1) begin
      wr(a_st, p[7:0] | 8'hfc);
      rc("prescale", a_st, 8'h07, p[7:0]);
      to_tick(n);
      to_tick(n);
      to_tick(n);
      chk("tick gap", 8'h02 << (2 * p), n[7:0]);
    end
    $display("test prescale done");
  endtask
  task t_write;
    wr(a_ad, 8'ha4);
    wr(a_ct, 8'h44);
    m.start;
    xfer(8'ha4, 8'h60, 8'h11);
    xfer(8'h3c, 8'h80, 8'h22);
    xstop;
    m.start;
    m.send(8'hb4, nack);
    chk("miss ack", 8'h01, {7'h0, nack});
    m.stop;
    rc("miss status", a_st, 8'hf8, 8'hf8);
    $display("test slave write done");
  endtask
  task t_gcall;
    wr(a_ad, 8'ha5);
    wr(a_mk, 8'hff);
    rc("mask", a_mk, 8'hff, 8'hfe);
    wr(a_mk, 8'h06);
    m.start;
    xfer(8'ha2, 8'h60, 8'h00);
    xstop;
    m.start;
    xfer(8'h00, 8'h70, 8'h00);
    xfer(8'h77, 8'h90, 8'h00);
    xstop;
    $display("test general call done");
  endtask
  task t_read;
    wr(a_mk, 8'h00);
    m.start;
    xfer(8'ha5, 8'ha8, 8'hc3);
    xget(1'b1, 8'hb8, 8'hc3, 8'h5a);
    xget(1'b0, 8'hc0, 8'h5a, 8'h00);
    m.stop;
    $display("test slave read done");
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      finish_test;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_rate;
    t_write;
    t_gcall;
    t_read;
    finish_test;
  end
endmodule // tb
